// file: lmf_pkg.sv
// Constants, types and register map of the LED matrix two-wire register front end.
// Assumes a system clock of 20 MHz and a separate oversampling clock for the bus side.
package lmf_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] LMF_MASK_OFS = 8'hF0;
    localparam logic [7:0] LMF_FLAGS_OFS = 8'hF1;
    localparam logic [7:0] LMF_PAGE_OFS = 8'hFD;
    localparam logic [7:0] LMF_KEY_OFS = 8'hFE;
    localparam logic [7:0] LMF_COMMON_BASE = 8'hF0;
    localparam logic [7:0] LMF_FAULT_LO = 8'h18;
    localparam logic [7:0] LMF_FAULT_HI = 8'h47;
    localparam logic [7:0] LMF_KEY_UNLOCK = 8'hC5;
    localparam logic [7:0] LMF_KEY_RESET = 8'h00;
    localparam logic [7:0] LMF_READ_NONE = 8'h00;
    localparam logic [1:0] LMF_PAGE_RESET = 2'h0;
    localparam logic [1:0] LMF_PAGE_FAULT = 2'h0;
    localparam logic [3:0] LMF_MASK_RESET = 4'h0;
    localparam logic [4:0] LMF_FLAGS_RESET = 5'h00;
    localparam logic [5:0] LMF_PAGE_RSVD_MASK = 6'h3F;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int LMF_MASK_OPEN = 0;
    localparam int LMF_MASK_SHORT = 1;
    localparam int LMF_MASK_BREATH = 2;
    localparam int LMF_MASK_AUTOCLR = 3;
    localparam int LMF_FLAG_OPEN = 0;
    localparam int LMF_FLAG_SHORT = 1;
    localparam int LMF_FLAG_BREATH = 2;

    // ----------------------------------------------------------------
    // Slave address
    // ----------------------------------------------------------------
    localparam logic [2:0] LMF_ADDR_FIXED = 3'h5;
    localparam logic [1:0] LMF_STRAP_GND = 2'h0;
    localparam logic [1:0] LMF_STRAP_VCC = 2'h1;
    localparam logic [1:0] LMF_STRAP_SCL = 2'h2;
    localparam logic [1:0] LMF_STRAP_SDA = 2'h3;
    localparam logic [3:0] LMF_LOW_GND = 4'h0;
    localparam logic [3:0] LMF_LOW_VCC = 4'hF;
    localparam logic [3:0] LMF_LOW_SCL = 4'h5;
    localparam logic [3:0] LMF_LOW_SDA = 4'hA;
    localparam logic [3:0] LMF_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LMF_LAST_OUT_BIT = 4'h7;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int LMF_AUTOCLR_MS = 8;
    localparam int LMF_SYS_PERIOD_NS = 50;
    localparam int LMF_AUTOCLR_CYCLES = (LMF_AUTOCLR_MS * 1000000) / LMF_SYS_PERIOD_NS + 1;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        LMF_IDLE, LMF_ADDR, LMF_ADDR_ACK, LMF_REG, LMF_REG_ACK,
        LMF_WDATA, LMF_WDATA_ACK, LMF_RDATA, LMF_RDATA_ACK, LMF_IGNORE
    } lmf_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } lmf_xfer_type;

    typedef struct packed {
        logic valid;
        logic [1:0] page;
        logic [7:0] addr;
        logic [7:0] data;
    } lmf_page_wr_type;

endpackage

// file: lmf_sync.sv
// Three-stage synchroniser with agreement filter for pins and cross-domain toggles.
// Assumes the input is a level that stays put for at least three destination clocks.
`timescale 1ns/1ps
module lmf_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_dout;

    // A change only counts once the last two stages agree.
    always_comb begin
        next_dout = dout;
        for (int i = 0; i < WIDTH; i++) begin
            if (stage2[i] == stage3[i]) begin
                next_dout[i] = stage3[i];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
            dout <= next_dout;
        end
    end
endmodule // lmf_sync

// file: lmf_front_end.sv
// Two-wire slave register front end: bus engine on the link clock, registers on sys_clk.
// Assumes scl and sda are oversampled by link_clk and the pad resolves sda from sda_oe.
//
// What this block does
// - Answer a seven-bit slave address plus direction bit; zero writes, one reads.
// - Address top bits are 101; low four bits follow the strap connection.
// - Start is sda falling while scl high; data sampled on scl high.
// - Sda rising while scl high ends the transfer.
// - Address byte arrives MSB first; matching address gets an acknowledge.
// - In a write the next byte is acknowledged and loads the register pointer.
// - Each data byte arrives MSB first, is acknowledged and stored at the pointer.
// - The pointer steps by one during each data byte acknowledge.
// - Only key, flags and page zero fault results read back; others are write-only.
// - Read is pointer write, repeated start, then address with read bit.
// - Page values 0 to 3 select LED, PWM, breathing and function pages.
// - Page select starts at zero and steers accesses below the common registers.
// - Page select ignores writes unless the key holds the unlock value.
// - Unlock value allows one page write; afterwards the key returns to zero.
// - Mask bits 0, 1, 2 enable open, short and breathing-done interrupts.
// - With mask bit 3 set, pending flags clear after irq held low over 8 ms.
// - Mask register is write-only, four used bits, resets to zero.
// - Flags hold breathing three, two, one done, short and open; reset zero.
`timescale 1ns/1ps
module lmf_front_end
    import lmf_pkg::*;
#(
    parameter int AUTOCLR_CYCLES = lmf_pkg::LMF_AUTOCLR_CYCLES
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic [1:0] strap_code,
    input wire logic open_evt,
    input wire logic short_evt,
    input wire logic [2:0] breath_done,
    output lmf_pkg::lmf_page_wr_type page_wr,
    output logic [7:0] page_rd_addr,
    input wire logic [7:0] page_rd_data,
    output logic [1:0] page_sel,
    output logic irq_out_low
);
    import lmf_pkg::*;

    // ----------------------------------------------------------------
    // Link domain: pin sampling and slave address
    // ----------------------------------------------------------------
    logic [1:0] pins;
    logic scl;
    logic sda;
    logic scl_d;
    logic sda_d;
    logic [3:0] addr_low;
    logic [3:0] next_addr_low;

    lmf_sync #(.WIDTH(2)) u_pin_sync (
        .clk(link_clk),
        .rst(sys_rst),
        .din({scl_in, sda_in}),
        .dout(pins)
    );
    logic [1:0] strap_s;
    lmf_sync #(.WIDTH(2)) u_strap_sync (
        .clk(link_clk),
        .rst(sys_rst),
        .din(strap_code),
        .dout(strap_s)
    );
    assign scl = pins[1];
    assign sda = pins[0];

    function automatic logic [3:0] strap_low(input logic [1:0] code);
        if (code == LMF_STRAP_VCC) begin
            strap_low = LMF_LOW_VCC;
        end else if (code == LMF_STRAP_SCL) begin
            strap_low = LMF_LOW_SCL;
        end else if (code == LMF_STRAP_SDA) begin
            strap_low = LMF_LOW_SDA;
        end else begin
            strap_low = LMF_LOW_GND;
        end
    endfunction

    // The strap is a static level, so it is followed all the time; catching it once would freeze the reset value.
    always_comb begin
        next_addr_low = strap_low(strap_s);
    end

    wire scl_rise = scl && !scl_d;
    wire scl_fall = !scl && scl_d;
    wire start_det = scl && scl_d && sda_d && !sda;
    wire stop_det = scl && scl_d && !sda_d && sda;
    wire [6:0] my_addr = {LMF_ADDR_FIXED, addr_low};

    // ----------------------------------------------------------------
    // Link domain: bus engine
    // ----------------------------------------------------------------
    lmf_state_type state, next_state;
    logic [3:0] bitcnt, next_bitcnt;
    logic [7:0] shreg, next_shreg;
    logic [7:0] ptr, next_ptr;
    logic oe, next_oe;
    logic wr_tgl, next_wr_tgl;
    logic rd_tgl, next_rd_tgl;
    lmf_xfer_type wr_req, next_wr_req;
    logic [7:0] rd_addr, next_rd_addr;
    logic [7:0] rd_byte, next_rd_byte;
    logic rd_ack_seen, next_rd_ack_seen;
    logic rd_ack_s;
    logic [7:0] rd_data, next_rd_data;

    always_comb begin
        next_state = state;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_ptr = ptr;
        next_oe = oe;
        next_wr_tgl = wr_tgl;
        next_rd_tgl = rd_tgl;
        next_wr_req = wr_req;
        next_rd_addr = rd_addr;
        next_rd_byte = rd_byte;
        next_rd_ack_seen = rd_ack_s;
        if (rd_ack_s != rd_ack_seen) begin
            next_rd_byte = rd_data;
        end
        if (start_det) begin
            next_state = LMF_ADDR;
            next_bitcnt = '0;
            next_oe = 1'b0;
        end else if (stop_det) begin
            next_state = LMF_IDLE;
            next_oe = 1'b0;
        end else begin
            case (state)
                LMF_ADDR, LMF_REG, LMF_WDATA: begin
                    if (scl_rise && bitcnt < LMF_BITS_PER_BYTE) begin
                        next_shreg = {shreg[6:0], sda};
                        next_bitcnt = bitcnt + 4'h1;
                    end else if (scl_fall && bitcnt == LMF_BITS_PER_BYTE) begin
                        next_oe = 1'b1;
                        if (state == LMF_ADDR) begin
                            if (shreg[7:1] == my_addr) begin
                                next_state = LMF_ADDR_ACK;
                                if (shreg[0]) begin
                                    next_rd_addr = ptr;
                                    next_rd_tgl = !rd_tgl;
                                end
                            end else begin
                                next_oe = 1'b0;
                                next_state = LMF_IGNORE;
                            end
                        end else if (state == LMF_REG) begin
                            next_ptr = shreg;
                            next_state = LMF_REG_ACK;
                        end else begin
                            next_wr_req.addr = ptr;
                            next_wr_req.data = shreg;
                            next_wr_tgl = !wr_tgl;
                            next_ptr = ptr + 8'h01;
                            next_state = LMF_WDATA_ACK;
                        end
                    end
                end
                LMF_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_bitcnt = '0;
                        if (shreg[0]) begin
                            next_state = LMF_RDATA;
                            next_shreg = rd_byte;
                            next_oe = !rd_byte[7];
                        end else begin
                            next_state = LMF_REG;
                            next_oe = 1'b0;
                        end
                    end
                end
                LMF_REG_ACK, LMF_WDATA_ACK: begin
                    if (scl_fall) begin
                        next_oe = 1'b0;
                        next_bitcnt = '0;
                        next_state = LMF_WDATA;
                    end
                end
                LMF_RDATA: begin
                    if (scl_fall) begin
                        if (bitcnt == LMF_LAST_OUT_BIT) begin
                            // The next byte is fetched now so it is ready before the following byte starts.
                            next_oe = 1'b0;
                            next_state = LMF_RDATA_ACK;
                            next_ptr = ptr + 8'h01;
                            next_rd_addr = ptr + 8'h01;
                            next_rd_tgl = !rd_tgl;
                        end else begin
                            next_shreg = {shreg[6:0], 1'b0};
                            next_oe = !shreg[6];
                            next_bitcnt = bitcnt + 4'h1;
                        end
                    end
                end
                LMF_RDATA_ACK: begin
                    if (scl_rise && sda) begin
                        next_state = LMF_IGNORE;
                    end else if (scl_fall) begin
                        next_state = LMF_RDATA;
                        next_bitcnt = '0;
                        next_shreg = rd_byte;
                        next_oe = !rd_byte[7];
                    end
                end
                default: begin
                    next_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            addr_low <= LMF_LOW_GND;
            state <= LMF_IDLE;
            bitcnt <= '0;
            shreg <= '0;
            ptr <= '0;
            oe <= 1'b0;
            wr_tgl <= 1'b0;
            rd_tgl <= 1'b0;
            wr_req <= '0;
            rd_addr <= '0;
            rd_byte <= '0;
            rd_ack_seen <= 1'b0;
        end else begin
            scl_d <= scl;
            sda_d <= sda;
            addr_low <= next_addr_low;
            state <= next_state;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            ptr <= next_ptr;
            oe <= next_oe;
            wr_tgl <= next_wr_tgl;
            rd_tgl <= next_rd_tgl;
            wr_req <= next_wr_req;
            rd_addr <= next_rd_addr;
            rd_byte <= next_rd_byte;
            rd_ack_seen <= next_rd_ack_seen;
        end
    end

    assign sda_oe = oe;
    assign sda_out = 1'b0;

    // ----------------------------------------------------------------
    // System domain: registers
    // ----------------------------------------------------------------
    logic wr_s, rd_s;
    logic wr_seen, next_wr_seen;
    logic rd_seen, next_rd_seen;
    logic rd_pend, next_rd_pend;
    logic rd_ack_tgl, next_rd_ack_tgl;
    logic [7:0] cap_addr, next_cap_addr;
    logic [7:0] key, next_key;
    logic [1:0] page, next_page;
    logic [3:0] mask, next_mask;
    logic [4:0] flags, next_flags;
    logic irq_q, next_irq_q;
    logic [31:0] low_cnt, next_low_cnt;
    lmf_page_wr_type next_page_wr;

    lmf_sync #(.WIDTH(2)) u_req_sync (
        .clk(sys_clk),
        .rst(sys_rst),
        .din({wr_tgl, rd_tgl}),
        .dout({wr_s, rd_s})
    );
    lmf_sync #(.WIDTH(1)) u_ack_sync (
        .clk(link_clk),
        .rst(sys_rst),
        .din(rd_ack_tgl),
        .dout(rd_ack_s)
    );

    // The request words were held stable for three clocks before their toggle is seen here.
    wire wr_go = wr_s != wr_seen;
    wire page_go = wr_go && wr_req.addr == LMF_PAGE_OFS && key == LMF_KEY_UNLOCK
        && (wr_req.data[7:2] & LMF_PAGE_RSVD_MASK) == 6'h00;
    wire [4:0] events = {breath_done[2], breath_done[1], breath_done[0], short_evt, open_evt};
    wire [4:0] enables = {{3{mask[LMF_MASK_BREATH]}}, mask[LMF_MASK_SHORT], mask[LMF_MASK_OPEN]};
    wire irq_req = |(flags & enables);
    wire autoclr_hit = mask[LMF_MASK_AUTOCLR] && irq_q && low_cnt >= 32'(AUTOCLR_CYCLES);

    always_comb begin
        next_wr_seen = wr_s;
        next_rd_seen = rd_s;
        next_rd_pend = 1'b0;
        next_rd_ack_tgl = rd_ack_tgl;
        next_rd_data = rd_data;
        next_cap_addr = cap_addr;
        next_key = key;
        next_page = page;
        next_mask = mask;
        next_flags = flags;
        next_page_wr = '0;
        if (rd_s != rd_seen) begin
            next_cap_addr = rd_addr;
            next_rd_pend = 1'b1;
        end
        if (rd_pend) begin
            if (cap_addr == LMF_KEY_OFS) begin
                next_rd_data = key;
            end else if (cap_addr == LMF_FLAGS_OFS) begin
                next_rd_data = {3'h0, flags};
                next_flags = LMF_FLAGS_RESET;
            end else if (page == LMF_PAGE_FAULT && cap_addr >= LMF_FAULT_LO && cap_addr <= LMF_FAULT_HI) begin
                next_rd_data = page_rd_data;
            end else begin
                next_rd_data = LMF_READ_NONE;
            end
            next_rd_ack_tgl = !rd_ack_tgl;
        end
        if (wr_go) begin
            if (wr_req.addr == LMF_KEY_OFS) begin
                next_key = wr_req.data;
            end else if (wr_req.addr == LMF_MASK_OFS) begin
                next_mask = wr_req.data[3:0];
            end else if (wr_req.addr < LMF_COMMON_BASE) begin
                next_page_wr.valid = 1'b1;
                next_page_wr.page = page;
                next_page_wr.addr = wr_req.addr;
                next_page_wr.data = wr_req.data;
            end
        end
        if (page_go) begin
            next_page = wr_req.data[1:0];
            next_key = LMF_KEY_RESET;
        end
        if (autoclr_hit) begin
            next_flags = LMF_FLAGS_RESET;
        end
        next_flags = next_flags | events;
        next_irq_q = irq_req;
        next_low_cnt = (irq_q && !autoclr_hit) ? low_cnt + 32'h1 : 32'h0;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_seen <= 1'b0;
            rd_seen <= 1'b0;
            rd_pend <= 1'b0;
            rd_ack_tgl <= 1'b0;
            rd_data <= LMF_READ_NONE;
            cap_addr <= '0;
            key <= LMF_KEY_RESET;
            page <= LMF_PAGE_RESET;
            mask <= LMF_MASK_RESET;
            flags <= LMF_FLAGS_RESET;
            irq_q <= 1'b0;
            low_cnt <= '0;
            page_wr <= '0;
        end else begin
            wr_seen <= next_wr_seen;
            rd_seen <= next_rd_seen;
            rd_pend <= next_rd_pend;
            rd_ack_tgl <= next_rd_ack_tgl;
            rd_data <= next_rd_data;
            cap_addr <= next_cap_addr;
            key <= next_key;
            page <= next_page;
            mask <= next_mask;
            flags <= next_flags;
            irq_q <= next_irq_q;
            low_cnt <= next_low_cnt;
            page_wr <= next_page_wr;
        end
    end

    assign irq_out_low = !irq_q;
    assign page_sel = page;
    assign page_rd_addr = cap_addr;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_unlocked_page_write;
        page_go;
    endsequence

    property p_key_one_shot;
        @(posedge sys_clk) disable iff (sys_rst) s_unlocked_page_write |=> key == LMF_KEY_RESET;
    endproperty
    a_key_one_shot: assert property (p_key_one_shot) else $error("Key not cleared after page write.");

    property p_page_locked;
        @(posedge sys_clk) disable iff (sys_rst)
            wr_go && wr_req.addr == LMF_PAGE_OFS && key != LMF_KEY_UNLOCK |=> $stable(page);
    endproperty
    a_page_locked: assert property (p_page_locked) else $error("Locked page select changed.");

    property p_irq_level;
        @(posedge sys_clk) disable iff (sys_rst) 1'b1 |=> irq_out_low == !$past(irq_req);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("Interrupt output wrong.");

    property p_flag_set;
        @(posedge sys_clk) disable iff (sys_rst) open_evt |=> flags[LMF_FLAG_OPEN];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("Open flag not set.");

    property p_mask_write;
        @(posedge sys_clk) disable iff (sys_rst)
            wr_go && wr_req.addr == LMF_MASK_OFS |=> mask == $past(wr_req.data[3:0]);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("Mask not written.");

    property p_autoclr;
        @(posedge sys_clk) disable iff (sys_rst) autoclr_hit && !(|events) |=> flags == LMF_FLAGS_RESET;
    endproperty
    a_autoclr: assert property (p_autoclr) else $error("Auto clear failed.");

    sequence s_data_byte_end;
        state == LMF_WDATA && scl_fall && bitcnt == LMF_BITS_PER_BYTE && !start_det && !stop_det;
    endsequence

    property p_ptr_step;
        @(posedge link_clk) disable iff (sys_rst)
            s_data_byte_end |=> ptr == $past(ptr) + 8'h01 && state == LMF_WDATA_ACK && oe;
    endproperty
    a_ptr_step: assert property (p_ptr_step) else $error("Pointer did not step.");

    property p_addr_ack;
        @(posedge link_clk) disable iff (sys_rst) state == LMF_ADDR_ACK |-> oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("Address not acknowledged.");

    property p_ignore_quiet;
        @(posedge link_clk) disable iff (sys_rst) state == LMF_IGNORE |-> !oe;
    endproperty
    a_ignore_quiet: assert property (p_ignore_quiet) else $error("Driving bus while ignoring.");

    property p_stop_idle;
        @(posedge link_clk) disable iff (sys_rst) stop_det && !start_det |=> state == LMF_IDLE && !oe;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("Stop not honoured.");
endmodule // lmf_front_end

// file: lmf_master.sv
// Behavioural two-wire bus master that drives the front end's bus pins.
// Assumes sda is resolved outside with a pull-up and scl idles high.
`timescale 1ns/1ps
module lmf_master (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    localparam int HALF = 800;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic start_cond();
        sda_low = 1'b0;
        #HALF scl = 1'b1;
        #HALF sda_low = 1'b1;
        #HALF scl = 1'b0;
    endtask
    task automatic stop_cond();
        sda_low = 1'b1;
        #HALF scl = 1'b1;
        #HALF sda_low = 1'b0;
        #HALF;
    endtask
    // Sampling in mid-high keeps clear of the slave's delayed data changes.
    task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            sda_low = !tx[i];
            #HALF scl = 1'b1;
            #(HALF / 2) rx[i] = sda;
            #(HALF / 2) scl = 1'b0;
        end
        sda_low = ack_in;
        #HALF scl = 1'b1;
        #(HALF / 2) ack_out = !sda;
        #(HALF / 2) scl = 1'b0;
    endtask
endmodule // lmf_master

// file: lmf_front_end_tb.sv
// Self-checking bench of the register front end against a queue-based model.
// Assumes lmf_master as bus partner and the auto-clear count shortened to 20.
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; $display("MISMATCH %0t compare", $time); end end
module lmf_front_end_tb;
    import lmf_pkg::*;
    logic sys_clk = 0, sys_rst = 1, link_clk = 0, open_evt = 0, short_evt = 0, a0;
    logic [2:0] breath_done = 0;
    logic [1:0] strap_code = 0;
    logic sda_out, sda_oe, irq_out_low;
    logic [1:0] page_sel;
    logic [7:0] page_rd_addr, page_rd_data, r0;
    lmf_page_wr_type page_wr;
    wire scl, sda_low;
    wire sda = !(sda_low || (sda_oe && !sda_out));
    int fails = 0, checked = 0, cyc = 0, key_m = 0, page_m = 0, flags_m = 0, mask_m = 0;
    logic [6:0] dev;
    logic [7:0] wq[$];
    logic [17:0] got_q[$], exp_q[$];
    assign page_rd_data = page_rd_addr ^ 8'h5A;
    initial forever #25 sys_clk = ~sys_clk;
    initial begin
        #7;
        forever #24 link_clk = ~link_clk;
    end
    lmf_master m_u (.scl(scl), .sda_low(sda_low), .sda(sda));
    lmf_front_end #(.AUTOCLR_CYCLES(20)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .link_clk(link_clk),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .strap_code(strap_code),
        .open_evt(open_evt), .short_evt(short_evt), .breath_done(breath_done), .page_wr(page_wr),
        .page_rd_addr(page_rd_addr), .page_rd_data(page_rd_data), .page_sel(page_sel), .irq_out_low(irq_out_low));
    always @(negedge sys_clk) if (page_wr.valid === 1'b1) got_q.push_back({page_wr.page, page_wr.addr, page_wr.data});
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            fails++;
            close_out();
        end
    end
    function automatic logic [7:0] m_rd(int p);
        logic [7:0] v;
        v = 8'h00;
        if (p == 8'hFE) v = key_m;
        if (p == 8'hF1) begin
            v = flags_m;
            flags_m = 0;
        end
        if (p >= 8'h18 && p <= 8'h47 && page_m == 0) v = p ^ 8'h5A;
        return v;
    endfunction
    task automatic bus(input logic [7:0] ptr, input int n, input logic rd);
        int p;
        p = ptr;
        m_u.start_cond();
        m_u.xfer({dev, 1'b0}, 1'b0, r0, a0);
        `CHK(a0, 1'b1)
        m_u.xfer(ptr, 1'b0, r0, a0);
        `CHK(a0, 1'b1)
        if (rd) begin
            m_u.start_cond();
            m_u.xfer({dev, 1'b1}, 1'b0, r0, a0);
            `CHK(a0, 1'b1)
            for (int i = 0; i < n; i++) begin
                m_u.xfer(8'hFF, i < n - 1, r0, a0);
                `CHK(r0, m_rd(p++))
            end
        end else foreach (wq[i]) begin
            m_u.xfer(wq[i], 1'b0, r0, a0);
            `CHK(a0, 1'b1)
            if (p < 8'hF0) exp_q.push_back({page_m[1:0], p[7:0], wq[i]});
            if (p == 8'hF0) mask_m = wq[i] & 8'h0F;
            if (p == 8'hFD && key_m == 8'hC5 && wq[i] < 4) begin
                page_m = wq[i];
                key_m = 0;
            end
            if (p == 8'hFE) key_m = wq[i];
            p++;
        end
        m_u.stop_cond();
        repeat (20) @(negedge sys_clk);
        `CHK(page_sel, page_m[1:0])
        `CHK(got_q.size(), exp_q.size())
        foreach (exp_q[i]) `CHK(got_q[i], exp_q[i])
        got_q = {};
        exp_q = {};
    endtask
    task automatic pulse(input logic [4:0] e);
        @(negedge sys_clk) {breath_done, short_evt, open_evt} = e;
        @(negedge sys_clk) {breath_done, short_evt, open_evt} = 5'h00;
        flags_m |= e;
        repeat (4) @(negedge sys_clk);
        `CHK(irq_out_low, !(|(flags_m & {{3{mask_m[2]}}, mask_m[1], mask_m[0]})))
    endtask
    task automatic close_out();
        if (fails == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h9212BF65));
        strap_code = 2'($urandom % 4);
        dev = {LMF_ADDR_FIXED, strap_code == 0 ? LMF_LOW_GND : strap_code == 1 ? LMF_LOW_VCC :
            strap_code == 2 ? LMF_LOW_SCL : LMF_LOW_SDA};
        repeat (20) @(negedge sys_clk);
        sys_rst = 0;
        repeat (20) @(negedge sys_clk);
        `CHK(irq_out_low, 1'b1)
        wq = '{8'h01};
        bus(8'hFD, 0, 0);
        wq = '{8'hC5};
        bus(8'hFE, 0, 0);
        bus(8'hFE, 1, 1);
        wq = '{8'h01};
        bus(8'hFD, 0, 0);
        bus(8'hFE, 1, 1);
        wq = '{8'($urandom), 8'($urandom), 8'($urandom)};
        bus(8'h10, 0, 0);
        wq = '{8'hC5, 8'h00};
        bus(8'hFE, 0, 0);
        wq = '{8'h00};
        bus(8'hFD, 0, 0);
        bus(8'h18, 2, 1);
        wq = '{8'h07};
        bus(8'hF0, 0, 0);
        pulse(5'h01);
        bus(8'hF1, 1, 1);
        wq = '{8'h0A};
        bus(8'hF0, 0, 0);
        pulse(5'h02);
        repeat (40) @(negedge sys_clk);
        flags_m = 0;
        `CHK(irq_out_low, 1'b1)
        pulse(5'h10);
        bus(8'hF1, 1, 1);
        m_u.start_cond();
        m_u.xfer({dev ^ 7'h01, 1'b0}, 1'b0, r0, a0);
        `CHK(a0, 1'b0)
        m_u.stop_cond();
        close_out();
    end
endmodule // lmf_front_end_tb
